// *** core/thc_monitor.sv ***
// Two-hand control monitor top: sequencing, feedback checks, LEDs, registers.
// Assumes inputs synchronous to clk_sys_i, high means pressed or closed.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module thc_monitor
  import thc_pkg::*;
#(
  parameter int unsigned SIMUL_CNT = SIMUL_CYCLES,
  parameter int unsigned FB_OFF_CNT = FB_OFF_CYCLES,
  parameter int unsigned FLASH_CNT = FLASH_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire thc_in_s pins_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o,
  output thc_out_s pins_o,
  output logic auto_mode_o
);
  // ==========================================================
  // State
  thc_state_e state; // Main state
  thc_state_e next_state; // Next main state
  logic [4:0] init_cnt; // Initialisation counter
  logic [4:0] status; // Sticky events
  logic [4:0] mask; // Interrupt mask
  logic off_fault; // Latched switch-off error
  logic pre_fault; // Pre-switch-on error pending
  logic out_q; // Safety outputs on
  logic [1:0] fb_watch; // Loops being checked after off
  logic flash_tick; // Flash period tick
  logic flash_phase; // Alternating phase
  logic [4:0] code_pos; // Position in flash code

  // ==========================================================
  // Decoding
  wire logic any_press = pins_i.button_one | pins_i.button_two;
  wire logic both_press = pins_i.button_one & pins_i.button_two;
  wire logic both_rel = !any_press;
  wire logic fb_one_ok = pins_i.feedback_loop_first;
  wire logic fb_two_ok = pins_i.feedback_loop_second;
  wire logic fb_ok = fb_one_ok & fb_two_ok;
  // link inputs, either the AND or the OR link alone enables
  wire logic link_ok = pins_i.and_link_input | pins_i.or_link_input;
  wire logic init_done = (init_cnt == 5'(INIT_CYCLES));
  wire logic simul_exp;
  wire logic fb_exp;
  wire logic flash_exp;
  wire logic wr_status = reg_wr_i && (reg_addr_i == ADR_STATUS);
  wire logic wr_mask = reg_wr_i && (reg_addr_i == ADR_MASK);
  // Sticky status events, one bit each
  wire logic ev_on = (state == THC_ARMED) && (next_state == THC_ON);
  wire logic ev_off = out_q && (next_state != THC_ON);
  wire logic ev_simul = (state == THC_ARMED) && simul_exp && both_press;
  wire logic ev_pre = (state == THC_ARMED) && both_press && !simul_exp && !fb_ok;
  // Watched loops that are still open after switch-off
  wire logic fb_pending = |(fb_watch & ~{fb_two_ok, fb_one_ok});
  wire logic ev_off_err = fb_exp && fb_pending && !off_fault;
  wire logic [4:0] events = {ev_off, ev_on, ev_simul, ev_off_err, ev_pre};

  // ==========================================================
  // Timers
  // Each timer reloads on its start event and counts down
  // Expiry stands while the timer keeps running, so a late second
  // press still sees the miss however long the first was held
  // window starts at first press
  thc_timer #(.COUNT(SIMUL_CNT)) u_simul (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(state == THC_IDLE),
    .run_i(state == THC_ARMED),
    .expired_o(simul_exp)
  );

  thc_timer #(.COUNT(FB_OFF_CNT)) u_fboff (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(ev_off),
    .run_i(fb_pending),
    .expired_o(fb_exp)
  );

  // Flash period
  thc_timer #(.COUNT(FLASH_CNT)) u_flash (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(flash_tick),
    .run_i(1'b1),
    .expired_o(flash_exp)
  );

  // ==========================================================
  // Next state
  // Lock check placed last: no button or loop action
  // may ever lead out of a switch-off fault
  always_comb begin
    next_state = state;
    unique case (state)
      THC_INIT: begin
        if (init_done) begin
          next_state = THC_WAIT_FB;
        end
      end
      THC_WAIT_FB: begin
        if (fb_ok && both_rel) begin
          next_state = THC_IDLE;
        end
      end
      THC_IDLE: begin
        if (!fb_ok) begin
          next_state = THC_WAIT_FB;
        end else if (any_press) begin
          next_state = THC_ARMED;
        end
      end
      THC_ARMED: begin
        if (both_rel) begin
          next_state = THC_IDLE;
        end else if (both_press && !simul_exp && fb_ok && link_ok) begin
          next_state = THC_ON;
        end else if (both_press && (simul_exp || !fb_ok)) begin
          next_state = THC_RELEASE;
        end
      end
      THC_ON: begin
        if (!both_press || !link_ok) begin
          next_state = THC_RELEASE;
        end
      end
      THC_RELEASE: begin
        if (both_rel) begin
          next_state = THC_WAIT_FB;
        end
      end
      THC_LOCKED: begin
        next_state = THC_LOCKED;
      end
      default: begin
        next_state = THC_LOCKED;
      end
    endcase
    if (off_fault || ev_off_err) begin
      next_state = THC_LOCKED;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= THC_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Initialisation counter and mode strap capture
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      init_cnt <= 5'h00;
      auto_mode_o <= 1'b0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 5'h01;
      auto_mode_o <= pins_i.mode_strap;
    end
  end

  // ==========================================================
  // Output enable and feedback tracking
  // Mirror of the safety outputs; its fall marks switch-off
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= (next_state == THC_ON);
    end
  end

  // watch each loop after its output falls
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fb_watch <= 2'h0;
    end else if (ev_off) begin
      fb_watch <= 2'h3;
    end else begin
      fb_watch <= fb_watch & ~{fb_two_ok, fb_one_ok};
    end
  end

  // fault latch, cleared by reset only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      off_fault <= 1'b0;
    end else if (ev_off_err) begin
      off_fault <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pre_fault <= 1'b0;
    end else if (ev_pre) begin
      pre_fault <= 1'b1;
    end else if (state == THC_IDLE) begin
      pre_fault <= 1'b0;
    end
  end

  // ==========================================================
  // Flash generation
  // One tick per flash slot; phase gives the alternate pattern
  // and the slot index walks the error code
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flash_tick <= 1'b0;
      flash_phase <= 1'b0;
      code_pos <= 5'h00;
    end else begin
      flash_tick <= flash_exp && !flash_tick;
      if (flash_tick) begin
        flash_phase <= !flash_phase;
        code_pos <= (code_pos == CODE_LEN - 5'h01) ? 5'h00 : code_pos + 5'h01;
      end
    end
  end

  // code 1,8: slot 0 one pulse, slots 4..19 eight pulses
  wire logic code_lit = (code_pos < 5'(2 * CODE_FIRST)) ? !code_pos[0] :
                        ((code_pos >= 5'h04) && (code_pos < 5'(4 + 2 * CODE_SECOND)))
                        ? !code_pos[0] : 1'b0;

  // ==========================================================
  // Pin outputs
  // Safety, aux and channel outputs taken from next_state so they move on the state's edge;
  // the lock forces the safety outputs low, channel LEDs show the code
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pins_o <= '0;
    end else begin
      pins_o.safety_one <= (next_state == THC_ON);
      pins_o.safety_two <= (next_state == THC_ON);
      pins_o.aux_status_output <= (next_state == THC_ON);
      pins_o.power_led <= (state != THC_INIT);
      if (off_fault) begin
        pins_o.channel_one_led <= code_lit;
        pins_o.channel_two_led <= code_lit;
      end else if (pre_fault) begin
        pins_o.channel_one_led <= flash_phase;
        pins_o.channel_two_led <= !flash_phase;
      end else begin
        pins_o.channel_one_led <= (next_state == THC_ON);
        pins_o.channel_two_led <= (next_state == THC_ON);
      end
    end
  end

  // ==========================================================
  // Registers: status set wins over clear
  // Write one clears a bit; an event in the same cycle
  // keeps its bit set so no event is lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      status <= 5'h00;
      mask <= MASK_RESET;
    end else begin
      status <= (status & ~(wr_status ? reg_wdata_i[4:0] : 5'h00)) | events;
      if (wr_mask) begin
        mask <= reg_wdata_i[4:0];
      end
    end
  end

  // Read data one cycle after the strobe, interrupt level
  // Interrupt follows the status value stored at this edge
  wire logic [7:0] rd_mux = (reg_addr_i == ADR_STATUS) ? {3'h0, status} :
                            (reg_addr_i == ADR_MASK) ? {3'h0, mask} :
                            (reg_addr_i == ADR_STATE) ? {1'b0, state} : 8'h00;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
      irq_o <= |(((status & ~(wr_status ? reg_wdata_i[4:0] : 5'h00)) | events) & mask);
    end
  end
endmodule : thc_monitor
`default_nettype wire

// *** core/thc_pkg.sv ***
// Package for the two-hand control monitor: timing, LED codes, carriers.
// Assumes a 200 MHz system clock and inputs synchronous to it.
package thc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SIMUL_MS = 500;
  localparam int unsigned FB_OFF_MS = 150;
  localparam int unsigned INIT_CYCLES = 16;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned SIMUL_CYCLES = CLK_HZ / 1000 * SIMUL_MS;
  localparam int unsigned FB_OFF_CYCLES = CLK_HZ / 1000 * FB_OFF_MS;
  localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;

  // ==========================================================
  // Flash code 1,8 pattern: one pulse, pause, eight pulses
  localparam int unsigned CODE_FIRST = 1;
  localparam int unsigned CODE_SECOND = 8;
  localparam logic [4:0] CODE_LEN = 5'h18;

  // ==========================================================
  // Status bits (sticky, write one to clear)
  localparam int unsigned ST_PRE_ERR = 0;
  localparam int unsigned ST_OFF_ERR = 1;
  localparam int unsigned ST_SIMUL_ERR = 2;
  localparam int unsigned ST_ON = 3;
  localparam int unsigned ST_OFF = 4;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // Register indices
  localparam logic [1:0] ADR_STATUS = 2'h0;
  localparam logic [1:0] ADR_MASK = 2'h1;
  localparam logic [1:0] ADR_STATE = 2'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic button_one;
    logic button_two;
    logic feedback_loop_first;
    logic feedback_loop_second;
    logic or_link_input;
    logic and_link_input;
    logic mode_strap;
  } thc_in_s;

  typedef struct packed {
    logic safety_one;
    logic safety_two;
    logic aux_status_output;
    logic power_led;
    logic channel_one_led;
    logic channel_two_led;
  } thc_out_s;

  // Main controller states
  typedef enum logic [6:0] {
    THC_INIT = 7'h01,
    THC_WAIT_FB = 7'h02,
    THC_IDLE = 7'h04,
    THC_ARMED = 7'h08,
    THC_ON = 7'h10,
    THC_RELEASE = 7'h20,
    THC_LOCKED = 7'h40
  } thc_state_e;

endpackage : thc_pkg

// *** core/thc_timer.sv ***
// Down counter giving a timeout pulse level after a load.
// Assumes a single clock; load restarts the count.
`timescale 1ns/1ps
`default_nettype none
module thc_timer #(
  parameter int unsigned COUNT = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic run_i,
  output logic expired_o
);
  // ==========================================================
  // Counter
  logic [31:0] cnt; // Remaining cycles
  wire logic zero = (cnt == 32'h0);

  // Load, count down while run holds
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || load_i) begin
      cnt <= 32'(COUNT);
    end else if (run_i && !zero) begin
      cnt <= cnt - 32'h1;
    end
  end

  // Expiry flag set while run holds at zero, cleared by load or run low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || load_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= run_i && zero;
    end
  end
endmodule : thc_timer
`default_nettype wire

// *** tb/tb_thc_monitor.sv ***
// Self-checking bench for the two-hand monitor.
// Assumes small counts: window 20, off timeout 10, flash slot 4.
`timescale 1ns/1ps
`default_nettype none
module tb_thc_monitor;
  import thc_pkg::*;
  // ==========================================================
  // Stimulus and wiring
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] press = 2'h0;
  logic [1:0] link = 2'h3;
  logic stuck = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata_dut;
  logic irq_dut;
  logic auto_dut;
  thc_out_s pins_dut;
  thc_in_s pins_in;
  // Copies of the outputs as they stand before each rising edge
  logic [7:0] rdata;
  logic irq;
  logic auto_mode;
  thc_out_s pins_out;
  int mismatches = 0;
  int compares = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  // Settled values taken mid-cycle, away from the launching edge
  always @(negedge clk_sys_i) begin
    rdata = rdata_dut;
    irq = irq_dut;
    auto_mode = auto_dut;
    pins_out = pins_dut;
  end

  thc_partner u_partner (.clk_sys_i(clk_sys_i), .press_i(press), .link_i(link),
    .stuck_i(stuck), .outs_i(pins_dut), .pins_o(pins_in));
  thc_monitor #(.SIMUL_CNT(20), .FB_OFF_CNT(10), .FLASH_CNT(4)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pins_i(pins_in), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_dut),
    .irq_o(irq_dut), .pins_o(pins_dut), .auto_mode_o(auto_dut));

  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(posedge clk_sys_i);
    chk("reg", exp, rdata);
  endtask : rd_reg
  task automatic end_sim;
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Watchdog
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end

  // ==========================================================
  // Tests
  initial begin
    cyc(6);
    rst_i <= 1'b0;
    cyc(40);
    chk("pins", 8'h04, 8'(pins_out));
    chk("auto", 8'h01, 8'(auto_mode));
    rd_reg(ADR_STATE, 8'h04);
    rd_reg(2'h3, 8'h00);
    wr_reg(ADR_MASK, 8'h1F);
    rd_reg(ADR_MASK, 8'h1F);
    press <= 2'h3;
    cyc(5);
    chk("pins", 8'h3F, 8'(pins_out));
    chk("irq", 8'h01, 8'(irq));
    rd_reg(ADR_STATUS, 8'h08);
    wr_reg(ADR_STATUS, 8'hFF);
    press <= 2'h2;
    cyc(2);
    chk("pins", 8'h04, 8'(pins_out));
    press <= 2'h3;
    cyc(5);
    chk("pins", 8'h04, 8'(pins_out));
    press <= 2'h0;
    cyc(10);
    rd_reg(ADR_STATUS, 8'h10);
    wr_reg(ADR_STATUS, 8'hFF);
    cyc(1);
    chk("irq", 8'h00, 8'(irq));
    press <= 2'h2;
    cyc(30);
    press <= 2'h3;
    cyc(5);
    chk("pins", 8'h04, 8'(pins_out));
    rd_reg(ADR_STATUS, 8'h04);
    press <= 2'h0;
    cyc(10);
    for (int i = 0; i < 4; i++) begin
      link <= 2'(i);
      press <= 2'h3;
      cyc(5);
      chk("pins", (i == 0) ? 8'h04 : 8'h3F, 8'(pins_out));
      press <= 2'h0;
      cyc(10);
    end
    wr_reg(ADR_STATUS, 8'hFF);
    press <= 2'h2;
    cyc(2);
    stuck <= 1'b1;
    press <= 2'h3;
    cyc(6);
    chk("safety", 8'h00, 8'(pins_out[5:3]));
    chk("alt", 8'h01, 8'(pins_out.channel_one_led ^ pins_out.channel_two_led));
    rd_reg(ADR_STATUS, 8'h01);
    stuck <= 1'b0;
    cyc(5);
    chk("safety", 8'h00, 8'(pins_out[5:3]));
    press <= 2'h0;
    cyc(10);
    press <= 2'h3;
    cyc(5);
    chk("pins", 8'h3F, 8'(pins_out));
    wr_reg(ADR_STATUS, 8'hFF);
    stuck <= 1'b1;
    press <= 2'h0;
    cyc(16);
    rd_reg(ADR_STATE, 8'h40);
    rd_reg(ADR_STATUS, 8'h12);
    stuck <= 1'b0;
    cyc(5);
    press <= 2'h3;
    cyc(5);
    chk("safety", 8'h00, 8'(pins_out[5:3]));
    rd_reg(ADR_STATE, 8'h40);
    press <= 2'h0;
    rst_i <= 1'b1;
    cyc(6);
    rst_i <= 1'b0;
    cyc(40);
    rd_reg(ADR_STATE, 8'h04);
    end_sim();
  end
endmodule : tb_thc_monitor
`default_nettype wire

// *** tb/thc_monitor_properties.sv ***
// Checker for the two-hand monitor top, bound to its ports.
// Assumes the single clk_sys_i domain and sync reset rst_i.
`timescale 1ns/1ps
`default_nettype none
module thc_monitor_properties
  import thc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire thc_in_s pins_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic irq_o,
  input wire thc_out_s pins_o,
  input wire logic auto_mode_o
);
  // ==========================================================
  // Helper: both buttons seen released since last switch-on
  logic rel_seen;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rel_seen <= 1'b0;
    end else if (pins_o.safety_one) begin
      rel_seen <= 1'b0;
    end else if (!pins_i.button_one && !pins_i.button_two) begin
      rel_seen <= 1'b1;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_OUT_PAIR: assert property (pins_o.safety_one |-> pins_o.safety_two
    && pins_o.aux_status_output && pins_o.channel_one_led && pins_o.channel_two_led)
    else $error("outputs not switched together");
  AST_RELEASE_OFF: assert property (pins_o.safety_one
    && !(pins_i.button_one && pins_i.button_two) |=> !pins_o.safety_one)
    else $error("outputs stay on after release");
  AST_LOOPS_CLOSED: assert property ($rose(pins_o.safety_one)
    |-> $past(pins_i.feedback_loop_first && pins_i.feedback_loop_second))
    else $error("switch-on with open loop");
  AST_BOTH_PRESSED: assert property ($rose(pins_o.safety_two)
    |-> $past(pins_i.button_one && pins_i.button_two))
    else $error("switch-on without both buttons");
  AST_LINK_ON: assert property ($rose(pins_o.safety_one)
    |-> $past(pins_i.or_link_input || pins_i.and_link_input))
    else $error("switch-on without link");
  AST_REARM: assert property ($rose(pins_o.safety_one) |-> $past(rel_seen))
    else $error("switch-on without prior release");
  AST_POWER_UP: assert property ($fell(rst_i) |-> ##[14:24] pins_o.power_led)
    else $error("power indicator late");
  AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped index returns data");

  // Main scenarios
  cover property ($rose(pins_o.safety_one));
  cover property (pins_o.channel_one_led != pins_o.channel_two_led);
  cover property (irq_o && auto_mode_o);
endmodule : thc_monitor_properties

bind thc_monitor thc_monitor_properties u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .pins_i(pins_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .pins_o(pins_o),
  .auto_mode_o(auto_mode_o));
`default_nettype wire

// *** tb/thc_partner.sv ***
// Operator buttons and contactor feedback contacts facing the monitor.
// Assumes the bench commands the hands, links and a welded contact.
`timescale 1ns/1ps
`default_nettype none
module thc_partner
  import thc_pkg::*;
#(
  parameter int unsigned DELAY = 3
) (
  input wire logic clk_sys_i,
  input wire logic [1:0] press_i,
  input wire logic [1:0] link_i,
  input wire logic stuck_i,
  input wire thc_out_s outs_i,
  output thc_in_s pins_o
);
  // ==========================================================
  // Contact close delay counters
  logic [7:0] cnt_one = 8'h00;
  logic [7:0] cnt_two = 8'h00;
  always_ff @(posedge clk_sys_i) begin
    cnt_one <= outs_i.safety_one ? 8'h00 : (cnt_one < DELAY ? cnt_one + 8'h01 : cnt_one);
    cnt_two <= outs_i.safety_two ? 8'h00 : (cnt_two < DELAY ? cnt_two + 8'h01 : cnt_two);
  end
  // Welded contact keeps loop one open
  assign pins_o = {press_i, (cnt_one >= DELAY) && !stuck_i, cnt_two >= DELAY, link_i, 1'b1};
endmodule : thc_partner
`default_nettype wire
